// ===== rpss_out_mux.sv
/*
  One output pin mux: picks a peripheral output by function number.
  Assumes function outputs and enables are synchronous to hclk.
*/
`timescale 1ns/1ps
module rpss_out_mux
  import rpss_pkg::*;
(
  input wire logic [4:0] func_sel,
  input wire logic [RPSS_NUM_FUNCS-1:0] func_out,
  input wire logic [RPSS_NUM_FUNCS-1:0] func_oe,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_remapped
);
  always_comb begin
    // Function zero hands the pin back to the port logic
    pin_remapped = (func_sel != RPSS_FUNC_NONE);
    pin_out = pin_remapped ? func_out[func_sel] : 1'b0;
    pin_oe = pin_remapped ? func_oe[func_sel] : 1'b0;
  end
endmodule

// ===== rpss_periph_model.sv
/* Far-side model: peripheral outputs by function number and pin levels.
   Assumes the bench sets pin levels and shares hclk. */
`timescale 1ns/1ps
module rpss_periph_model
  import rpss_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [RPSS_NUM_PINS-1:0] pin_level,
  output logic [RPSS_NUM_PINS-1:0] remappable_pin,
  output logic [RPSS_NUM_FUNCS-1:0] func_out,
  output logic [RPSS_NUM_FUNCS-1:0] func_oe
);
  // Patterns move every cycle so a stuck mux cannot match by luck
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      func_out <= 32'hA5C3_0F96;
      func_oe <= 32'h3C5A_96E1;
    end else begin
      func_out <= {func_out[30:0], func_out[31]};
      func_oe <= {func_oe[0], func_oe[31:1]};
    end
  end
  assign remappable_pin = pin_level;
endmodule

// ===== rpss_pkg.sv
/*
  Package for the remappable pin select slice: register offsets, field
  layouts, reset values and bus encodings.
  Assumes a single AHB-Lite master and one 50 MHz clock domain.
*/
package rpss_pkg;
  localparam int RPSS_NUM_PINS = 31;
  localparam int RPSS_NUM_OUT_PINS = 6;
  localparam int RPSS_FIELD_W = 5;
  localparam int RPSS_NUM_FUNCS = 32;
  localparam int RPSS_REG_W = 16;
  localparam int RPSS_EVEN_LSB = 0;
  localparam int RPSS_ODD_LSB = 8;
  localparam logic [4:0] RPSS_SEL_GROUND = 5'h1F;
  localparam logic [4:0] RPSS_FUNC_NONE = 5'h00;
  localparam logic [4:0] RPSS_IN_SEL_RESET = 5'h1F;
  localparam logic [4:0] RPSS_OUT_SEL_RESET = 5'h00;
  localparam logic [15:0] RPSS_FIELD_MASK = 16'h1F1F;
  localparam logic [11:0] RPSS_ADDR_OUT01 = 12'h000;
  localparam logic [11:0] RPSS_ADDR_OUT23 = 12'h004;
  localparam logic [11:0] RPSS_ADDR_OUT45 = 12'h008;
  localparam logic [11:0] RPSS_ADDR_IN_SS = 12'h00C;
  localparam logic [1:0] RPSS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] RPSS_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] RPSS_HSIZE_WORD = 3'h2;
  localparam logic [31:0] RPSS_RDATA_ZERO = 32'h0000_0000;
endpackage

// ===== rpss_top.sv
/*
  Remappable pin select slice: slave select input routing for serial
  port 1 and output function select for remappable pins 0 to 5, with
  an AHB-Lite register slave.
  Assumes pins are asynchronous to hclk; peripheral outputs are not.
*/
`timescale 1ns/1ps
module rpss_top
  import rpss_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [RPSS_NUM_PINS-1:0] remappable_pin,
  output logic serial1_slave_sel_input,
  input wire logic [RPSS_NUM_FUNCS-1:0] func_out,
  input wire logic [RPSS_NUM_FUNCS-1:0] func_oe,
  output logic [RPSS_NUM_OUT_PINS-1:0] pin_out,
  output logic [RPSS_NUM_OUT_PINS-1:0] pin_oe,
  output logic [RPSS_NUM_OUT_PINS-1:0] pin_remapped
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [RPSS_NUM_PINS-1:0] pin_meta;
  logic [RPSS_NUM_PINS-1:0] pin_sync;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (clk_en) begin
      pin_meta <= remappable_pin;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus address phase capture

  logic wr_pend;
  logic rd_pend;
  logic [11:0] addr_q;
  logic next_wr_pend;
  logic next_rd_pend;
  logic [11:0] next_addr_q;
  logic addr_ok;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == RPSS_ADDR_OUT01) || (a == RPSS_ADDR_OUT23) ||
                (a == RPSS_ADDR_OUT45) || (a == RPSS_ADDR_IN_SS);
  endfunction

  always_comb begin
    addr_ok = hsel && hready && clk_en &&
              (htrans == RPSS_HTRANS_NONSEQ || htrans == RPSS_HTRANS_SEQ);
    next_wr_pend = addr_ok && hwrite && hsize == RPSS_HSIZE_WORD && is_mapped(haddr);
    next_rd_pend = addr_ok && !hwrite;
    next_addr_q = addr_ok ? haddr : addr_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= '0;
    end else if (clk_en) begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      addr_q <= next_addr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Select fields

  logic [4:0] out_func [RPSS_NUM_OUT_PINS];
  logic [4:0] next_out_func [RPSS_NUM_OUT_PINS];
  logic [4:0] slave_sel_source_field;
  logic [4:0] next_slave_sel_source_field;

  function automatic logic [4:0] even_field(input logic [31:0] d);
    even_field = d[RPSS_EVEN_LSB +: RPSS_FIELD_W];
  endfunction

  function automatic logic [4:0] odd_field(input logic [31:0] d);
    odd_field = d[RPSS_ODD_LSB +: RPSS_FIELD_W];
  endfunction

  always_comb begin
    for (int i = 0; i < RPSS_NUM_OUT_PINS; i++) begin
      next_out_func[i] = out_func[i];
    end
    next_slave_sel_source_field = slave_sel_source_field;
    if (wr_pend) begin
      case (addr_q)
        RPSS_ADDR_OUT01: begin
          next_out_func[0] = even_field(hwdata);
          next_out_func[1] = odd_field(hwdata);
        end
        RPSS_ADDR_OUT23: begin
          next_out_func[2] = even_field(hwdata);
          next_out_func[3] = odd_field(hwdata);
        end
        RPSS_ADDR_OUT45: begin
          next_out_func[4] = even_field(hwdata);
          next_out_func[5] = odd_field(hwdata);
        end
        RPSS_ADDR_IN_SS: begin
          next_slave_sel_source_field = even_field(hwdata);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < RPSS_NUM_OUT_PINS; i++) begin
        out_func[i] <= RPSS_OUT_SEL_RESET;
      end
      slave_sel_source_field <= RPSS_IN_SEL_RESET;
    end else if (clk_en) begin
      for (int i = 0; i < RPSS_NUM_OUT_PINS; i++) begin
        out_func[i] <= next_out_func[i];
      end
      slave_sel_source_field <= next_slave_sel_source_field;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] next_hrdata;

  function automatic logic [31:0] pack_pair(input logic [4:0] ev, input logic [4:0] od);
    logic [31:0] w;
    w = '0;
    w[RPSS_EVEN_LSB +: RPSS_FIELD_W] = ev;
    w[RPSS_ODD_LSB +: RPSS_FIELD_W] = od;
    pack_pair = w & {16'h0000, RPSS_FIELD_MASK};
  endfunction

  always_comb begin
    next_hrdata = RPSS_RDATA_ZERO;
    if (next_rd_pend) begin
      case (haddr)
        RPSS_ADDR_OUT01: next_hrdata = pack_pair(out_func[0], out_func[1]);
        RPSS_ADDR_OUT23: next_hrdata = pack_pair(out_func[2], out_func[3]);
        RPSS_ADDR_OUT45: next_hrdata = pack_pair(out_func[4], out_func[5]);
        RPSS_ADDR_IN_SS: next_hrdata = pack_pair(slave_sel_source_field, 5'h00);
        default: next_hrdata = RPSS_RDATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RPSS_RDATA_ZERO;
    end else if (clk_en) begin
      hrdata <= next_hrdata;
    end
  end

  // Zero wait states; every access answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Slave select input routing

  logic next_ss_in;

  always_comb begin
    if (slave_sel_source_field == RPSS_SEL_GROUND) begin
      next_ss_in = 1'b0;
    end else begin
      next_ss_in = pin_sync[slave_sel_source_field];
    end
  end

  // Registered so the peripheral sees a clean level on a select change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial1_slave_sel_input <= 1'b0;
    end else if (clk_en) begin
      serial1_slave_sel_input <= next_ss_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output pin muxes

  for (genvar p = 0; p < RPSS_NUM_OUT_PINS; p++) begin : g_out
    rpss_out_mux u_mux (
      .func_sel(out_func[p]),
      .func_out(func_out),
      .func_oe(func_oe),
      .pin_out(pin_out[p]),
      .pin_oe(pin_oe[p]),
      .pin_remapped(pin_remapped[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_ss_ground;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && slave_sel_source_field == RPSS_SEL_GROUND |=> !serial1_slave_sel_input;
  endproperty
  a_ss_ground: assert property (p_ss_ground) else $error("slave select not grounded");

  property p_ss_route;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && slave_sel_source_field != RPSS_SEL_GROUND
      |=> serial1_slave_sel_input == $past(pin_sync[slave_sel_source_field]);
  endproperty
  a_ss_route: assert property (p_ss_route) else $error("slave select wrong pin");

  property p_in_write;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && wr_pend && addr_q == RPSS_ADDR_IN_SS
      |=> slave_sel_source_field == $past(hwdata[4:0]);
  endproperty
  a_in_write: assert property (p_in_write) else $error("input select write lost");

  property p_even_write;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && wr_pend && addr_q == RPSS_ADDR_OUT01 |=> out_func[0] == $past(hwdata[4:0]);
  endproperty
  a_even_write: assert property (p_even_write) else $error("even field write lost");

  property p_odd_write;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && wr_pend && addr_q == RPSS_ADDR_OUT45 |=> out_func[5] == $past(hwdata[12:8]);
  endproperty
  a_odd_write: assert property (p_odd_write) else $error("odd field write lost");

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
    (hrdata & ~{16'h0000, RPSS_FIELD_MASK}) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_read_back;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && next_rd_pend && haddr == RPSS_ADDR_OUT23 && !wr_pend
      |=> hrdata[12:8] == out_func[3];
  endproperty
  a_read_back: assert property (p_read_back) else $error("read back mismatch");

  property p_func_none;
    @(posedge hclk) disable iff (!hresetn)
    out_func[0] == RPSS_FUNC_NONE |-> !pin_oe[0] && !pin_remapped[0];
  endproperty
  a_func_none: assert property (p_func_none) else $error("pin 0 driven at function 0");

  property p_func_drive;
    @(posedge hclk) disable iff (!hresetn)
    out_func[2] != RPSS_FUNC_NONE |-> pin_out[2] == func_out[out_func[2]];
  endproperty
  a_func_drive: assert property (p_func_drive) else $error("pin 2 wrong function");

  property p_func_enable;
    @(posedge hclk) disable iff (!hresetn)
    out_func[5] != RPSS_FUNC_NONE |-> pin_oe[5] == func_oe[out_func[5]];
  endproperty
  a_func_enable: assert property (p_func_enable) else $error("pin 5 wrong enable");

  property p_in_read;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && next_rd_pend && haddr == RPSS_ADDR_IN_SS && !wr_pend
      |=> hrdata == {27'h0000000, slave_sel_source_field};
  endproperty
  a_in_read: assert property (p_in_read) else $error("input select read back wrong");

  property p_unmapped_read;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && next_rd_pend && !is_mapped(haddr) |=> hrdata == RPSS_RDATA_ZERO;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // Clock enable low must hold the input select, out_func[3], hrdata and the slave select output
  property p_freeze;
    @(posedge hclk) disable iff (!hresetn)
    !clk_en |=> $stable(slave_sel_source_field) && $stable(out_func[3]) && $stable(hrdata)
      && $stable(serial1_slave_sel_input);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  c_ss_pin: cover property (@(posedge hclk) disable iff (!hresetn)
    slave_sel_source_field == 5'h1E && serial1_slave_sel_input);
  c_out_map: cover property (@(posedge hclk) disable iff (!hresetn) pin_oe[5]);
  c_write: cover property (@(posedge hclk) disable iff (!hresetn) wr_pend);
  c_freeze: cover property (@(posedge hclk) disable iff (!hresetn) !clk_en && hsel);
  c_ground: cover property (@(posedge hclk) disable iff (!hresetn)
    slave_sel_source_field == RPSS_SEL_GROUND && pin_sync[0]);
endmodule

// ===== testbench.sv
/* Self-checking bench for the pin select slice.
   Assumes an AHB-Lite slave with hreadyout as hready. */
`timescale 1ns/1ps
module testbench
  import rpss_pkg::*;
;
  logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp, ss_in;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [RPSS_NUM_PINS-1:0] pin_level, pins;
  logic [RPSS_NUM_FUNCS-1:0] fo, foe;
  logic [5:0] p_out, p_oe, p_rm;
  logic [4:0] fsel [6];
  int failures, comparisons, cycles;

  rpss_top DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .remappable_pin(pins),
    .serial1_slave_sel_input(ss_in), .func_out(fo), .func_oe(foe), .pin_out(p_out),
    .pin_oe(p_oe), .pin_remapped(p_rm));
  rpss_periph_model peers (.hclk(hclk), .hresetn(hresetn), .pin_level(pin_level),
    .remappable_pin(pins), .func_out(fo), .func_oe(foe));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      failures = failures + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Single word transfer; each phase held until hready is seen high at a rising edge
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= RPSS_HSIZE_WORD;
    htrans <= RPSS_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    cmp({31'h0, hresp}, 32'h0, "bus response");
  endtask

  task automatic chk_pins();
    logic [4:0] f;
    @(negedge hclk);
    for (int p = 0; p < 6; p++) begin
      f = fsel[p];
      cmp({29'h0, p_out[p], p_oe[p], p_rm[p]},
        {29'h0, (f != 0) && fo[f], (f != 0) && foe[f], f != 0}, "pin mux");
    end
    @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {clk_en, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    clk_en = 1'b1;
    pin_level = '0;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(12'(4 * i), 1'b0, 32'h0);
      cmp(rd, (i == 3) ? 32'h0000_001F : 32'h0, "reset value");
    end
    $display("Test reset values done");
    for (int i = 0; i < 4; i++) begin
      xfer(12'(4 * i), 1'b1, 32'hFFFF_FFFF);
      xfer(12'(4 * i), 1'b0, 32'h0);
      cmp(rd, (i == 3) ? 32'h0000_001F : 32'h0000_1F1F, "field mask");
    end
    xfer(12'h010, 1'b0, 32'h0);
    cmp(rd, 32'h0, "unmapped read");
    $display("Test field layout done");
    // Every function number reaches every pin, zero included
    for (int f = 0; f < 32; f++) begin
      for (int r = 0; r < 3; r++) begin
        fsel[2 * r] = 5'(f + r);
        fsel[2 * r + 1] = 5'(31 - f - r);
        xfer(12'(4 * r), 1'b1, {19'h0, fsel[2 * r + 1], 3'h0, fsel[2 * r]});
      end
      chk_pins();
    end
    $display("Test output select done");
    // Lone pin high, then lone pin low; value 31 must ignore all pins
    for (int n = 0; n < 32; n++) begin
      xfer(RPSS_ADDR_IN_SS, 1'b1, 32'(n));
      for (int lvl = 0; lvl < 2; lvl++) begin
        pin_level <= (lvl == 1) ? ~(31'h1 << n) : (31'h1 << n);
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        cmp({31'h0, ss_in}, (n < 31 && lvl == 0) ? 32'h1 : 32'h0, "slave sel");
        @(posedge hclk);
      end
    end
    // Clock enable low freezes both the bus and the pin path
    xfer(RPSS_ADDR_IN_SS, 1'b1, 32'h0000_0005);
    repeat (2) @(posedge hclk);
    clk_en <= 1'b0;
    pin_level <= '0;
    xfer(RPSS_ADDR_IN_SS, 1'b1, 32'h0000_0009);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    cmp({31'h0, ss_in}, 32'h1, "frozen slave sel");
    @(posedge hclk);
    clk_en <= 1'b1;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    cmp({31'h0, ss_in}, 32'h0, "slave sel after freeze");
    @(posedge hclk);
    xfer(RPSS_ADDR_IN_SS, 1'b0, 32'h0);
    cmp(rd, 32'h0000_0005, "write with clock enable low");
    $display("Test slave select done");
    summarize();
  end
endmodule
